// ==== common/iowin_pkg.sv ====
package iowin_pkg;
   // register offsets on the local register port
   localparam logic [11:0] BASE_SIZE_OFFSET = 12'h0c4;
   localparam logic [11:0] CONTROL_OFFSET   = 12'h0f4;
   // field positions in the base/size register
   localparam int          BASE_LSB         = 12;
   localparam int          BASE_MSB         = 31;
   localparam int          ENABLE_BIT       = 7;
   localparam int          SPAN_LSB         = 0;
   localparam int          SPAN_MSB         = 4;
   // writable bits; reserved 11:8 and 6:5 are kept at zero
   localparam logic [31:0] BASE_SIZE_WMASK  = 32'hffff_f09f;
   localparam logic [31:0] BASE_SIZE_RESET  = 32'h0000_0000;
   localparam logic [31:0] CONTROL_READ     = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;
   // span coding: codes up to the threshold give the smallest window
   localparam logic [4:0]  SPAN_THRESHOLD   = 5'h07;
   localparam logic [5:0]  MIN_SPAN_EXP     = 6'h08;
   localparam logic [31:0] CLAIM_RESET      = 32'h0000_0000;
endpackage

// ==== hdl/iowin_match.sv ====
`timescale 1ns/1ps
module iowin_match
(
   input  wire logic [31:0] addr_in,
   input  wire logic [31:0] base_size_in,
   input  wire logic [4:0]  global_span_code_in,
   output logic             hit_out,
   output logic [31:0]      offset_out
);
   // log2 of the span in bytes for one size code
   function automatic logic [5:0] iowin_span_exp(input logic [4:0] code);
      logic [5:0] e;
      e = iowin_pkg::MIN_SPAN_EXP;
      if (code > iowin_pkg::SPAN_THRESHOLD)
      begin
         e = {1'b0, code} + 6'h01; // R6
      end
      return e;
   endfunction

   logic [5:0]  win_exp;
   logic [5:0]  glb_exp;
   logic [5:0]  use_exp;
   logic [31:0] keep_mask;
   logic [31:0] base_addr;

   // the wider of the two spans decides how many upper bits are compared
   always_comb
   begin
      win_exp = iowin_span_exp(base_size_in[iowin_pkg::SPAN_MSB:iowin_pkg::SPAN_LSB]); // R5
      glb_exp = iowin_span_exp(global_span_code_in);
      use_exp = (win_exp > glb_exp) ? win_exp : glb_exp; // R2
      for (int i = 0; i < 32; i++)
      begin
         keep_mask[i] = (i >= int'(use_exp));
      end
      base_addr = {base_size_in[iowin_pkg::BASE_MSB:iowin_pkg::BASE_LSB], 12'h000}; // R1
      hit_out = base_size_in[iowin_pkg::ENABLE_BIT]
                && ((addr_in & keep_mask) == (base_addr & keep_mask)); // R8
      offset_out = addr_in & ~keep_mask; // R8
   end
endmodule

// ==== hdl/iowin_decode.sv ====
`timescale 1ns/1ps
// Overview of operation
// R1: bits 31 to 12 of the base/size register hold the window base in host address space.
// R2: the number of upper bits compared follows from both the global and the window span codes.
// R3: writing bit 7 as one opens the window and writing it as zero closes it.
// R4: software writes zero to bits 6 and 5 and ignores what they read back.
// R5: the five-bit span code sets the compared bits, with 256 bytes as the smallest window.
// R6: a span code above seven gives a window of two to the power of code plus one bytes.
// R7: the control register takes only zero writes and its read value carries no meaning.
// R8: an access is claimed only with the window open and the upper bits equal to the base.
module iowin_decode
(
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        reg_wr_en_in,
   input  wire logic        reg_rd_en_in,
   input  wire logic [11:0] reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   output logic [31:0]      reg_rdata_out,
   output logic             reg_rd_valid_out,
   input  wire logic [4:0]  global_span_code_in,
   input  wire logic        host_req_in,
   input  wire logic [31:0] host_addr_in,
   output logic             claim_out,
   output logic [31:0]      claim_offset_out,
   output logic             aperture_on_bit_out
);
   // register state and the next values that feed it
   logic [31:0] io_window_base_and_size;
   logic [31:0] next_io_window_base_and_size;
   logic [31:0] next_reg_rdata;
   logic        next_reg_rd_valid;
   logic        next_claim;
   logic [31:0] next_claim_offset;
   logic        match_hit;
   logic [31:0] match_offset;
   logic        sel_base;
   logic        sel_ctrl;

   // register select decode and the enable bit seen by the local port
   assign sel_base = (reg_addr_in == iowin_pkg::BASE_SIZE_OFFSET);
   assign sel_ctrl = (reg_addr_in == iowin_pkg::CONTROL_OFFSET);
   assign aperture_on_bit_out = io_window_base_and_size[iowin_pkg::ENABLE_BIT];

   // span arithmetic kept in its own module so the compare stays purely combinational
   iowin_match u_match
   (
      .addr_in             (host_addr_in),
      .base_size_in        (io_window_base_and_size),
      .global_span_code_in (global_span_code_in),
      .hit_out             (match_hit),
      .offset_out          (match_offset)
   );

   // register writes; reserved bits are dropped so they always read zero
   always_comb
   begin
      next_io_window_base_and_size = io_window_base_and_size;
      if (reg_wr_en_in && sel_base)
      begin
         next_io_window_base_and_size = reg_wdata_in & iowin_pkg::BASE_SIZE_WMASK; // R1 R3 R4
      end
      // control register writes have no effect on any state
      // bits 11:8 are dropped too, so a small window base always sits on a 4 KB step
   end

   // read data is registered, valid one cycle after the strobe
   always_comb
   begin
      // a write in the same cycle is not seen here: reads return the old word
      next_reg_rd_valid = reg_rd_en_in;
      next_reg_rdata    = iowin_pkg::UNMAPPED_READ;
      if (reg_rd_en_in && sel_base)
      begin
         next_reg_rdata = io_window_base_and_size;
      end
      else if (reg_rd_en_in && sel_ctrl)
      begin
         next_reg_rdata = iowin_pkg::CONTROL_READ; // R7
      end
   end

   // claim is registered so the local port sees a clean one-cycle answer
   always_comb
   begin
      next_claim        = host_req_in && match_hit; // R8
      // offset holds between requests so the local port may use it late
      next_claim_offset = claim_offset_out;
      if (host_req_in)
      begin
         next_claim_offset = match_offset;
      end
   end

   // window register: the only state host software can change
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         io_window_base_and_size <= iowin_pkg::BASE_SIZE_RESET;
      end
      else
      begin
         io_window_base_and_size <= next_io_window_base_and_size; // R1 R3
      end
   end

   // read response; data falls back to zero so stale words never linger
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         reg_rdata_out    <= iowin_pkg::UNMAPPED_READ;
         reg_rd_valid_out <= 1'b0;
      end
      else
      begin
         reg_rdata_out    <= next_reg_rdata;
         reg_rd_valid_out <= next_reg_rd_valid;
      end
   end

   // claim answer; one cycle of latency bought for a glitch free local port
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         claim_out        <= 1'b0;
         claim_offset_out <= iowin_pkg::CLAIM_RESET;
      end
      else
      begin
         claim_out        <= next_claim;
         claim_offset_out <= next_claim_offset;
      end
   end

   // checks on register and decode behaviour
   chk_enable_set: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R3
      (reg_wr_en_in && sel_base && reg_wdata_in[7]) |=> aperture_on_bit_out)
      else $error("window not enabled after write of bit 7");
   chk_enable_clear: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R3
      (reg_wr_en_in && sel_base && !reg_wdata_in[7]) |=> !aperture_on_bit_out)
      else $error("window not disabled after clear of bit 7");
   chk_base_stored: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R1
      (reg_wr_en_in && sel_base) |=>
      (io_window_base_and_size[31:12] == $past(reg_wdata_in[31:12])))
      else $error("base address bits not stored");
   chk_reserved_zero: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R4
      (reg_rd_en_in && sel_base) |=> (reg_rd_valid_out && reg_rdata_out[6:5] == 2'b00))
      else $error("reserved bits read nonzero");
   chk_ctrl_inert: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R7
      (reg_wr_en_in && sel_ctrl) |=> $stable(io_window_base_and_size))
      else $error("control write changed window state");
   chk_claim_enabled: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R8
      claim_out |-> ($past(aperture_on_bit_out) && $past(host_req_in)))
      else $error("claim without enabled window");
   chk_min_span: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R5
      (host_req_in && aperture_on_bit_out && !reg_wr_en_in
       && io_window_base_and_size[4:0] <= 5'h07 && global_span_code_in <= 5'h07
       && host_addr_in[31:12] == io_window_base_and_size[31:12]
       && host_addr_in[11:8] == 4'h0) |=> claim_out)
      else $error("access inside 256 byte window not claimed");
   chk_large_span: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R2 R6
      (host_req_in && aperture_on_bit_out
       && io_window_base_and_size[4:0] == 5'h0c && global_span_code_in <= 5'h0c
       && host_addr_in[31:13] == io_window_base_and_size[31:13]) |=> claim_out)
      else $error("access inside 8 KB window not claimed");
   chk_offset_low: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R8
      claim_out |-> (claim_offset_out[7:0] == $past(host_addr_in[7:0])))
      else $error("offset low bits lost");

   // read port and register write checks
   chk_ctrl_read: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R7
      (reg_rd_en_in && sel_ctrl) |=>
      (reg_rd_valid_out && reg_rdata_out == iowin_pkg::CONTROL_READ))
      else $error("control register read not answered");
   chk_rd_base: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R1
      (reg_rd_en_in && sel_base) |=>
      (reg_rdata_out == $past(io_window_base_and_size)))
      else $error("base register read returned wrong word");
   chk_rd_pulse: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R1 R7
      reg_rd_valid_out |-> $past(reg_rd_en_in))
      else $error("read valid without a read strobe");
   chk_reserved_mask: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R4
      (reg_wr_en_in && sel_base) |=>
      (io_window_base_and_size[11:8] == 4'h0 && io_window_base_and_size[6:5] == 2'b00))
      else $error("reserved bits stored on write");
   chk_span_stored: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R5
      (reg_wr_en_in && sel_base) |=>
      (io_window_base_and_size[4:0] == $past(reg_wdata_in[4:0])))
      else $error("span code not stored");

   // host decode checks
   chk_closed_quiet: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R3 R8
      (host_req_in && !aperture_on_bit_out) |=> !claim_out)
      else $error("claim while window disabled");
   chk_base_miss: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R2 R5 R8
      (host_req_in && io_window_base_and_size[4:0] <= 5'h07 && global_span_code_in <= 5'h07
       && host_addr_in[31:8] != {io_window_base_and_size[31:12], 4'h0}) |=> !claim_out)
      else $error("access outside 256 byte window claimed");
   chk_offset_held: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R8
      !host_req_in |=> $stable(claim_offset_out))
      else $error("offset moved without a request");
   chk_offset_small: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R5 R8
      (host_req_in && io_window_base_and_size[4:0] <= 5'h07 && global_span_code_in <= 5'h07)
      |=> (claim_offset_out[31:8] == 24'h0))
      else $error("offset wider than 256 byte window");
   // the widest code compares no bits at all, so the window covers everything
   chk_span_all: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R6
      (host_req_in && aperture_on_bit_out && io_window_base_and_size[4:0] == 5'h1f) |=> claim_out)
      else $error("widest window did not claim");

   // scenarios worth seeing in coverage
   cov_enable: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      $rose(aperture_on_bit_out));
   cov_claim: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      claim_out ##1 claim_out);
   cov_miss: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      host_req_in && aperture_on_bit_out ##1 !claim_out);
   cov_wide_claim: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      host_req_in && match_hit && io_window_base_and_size[4:0] > 5'h07 ##1 claim_out);
   cov_write_read: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_wr_en_in && reg_rd_en_in && sel_base);
endmodule

// ==== tb/iowin_host.sv ====
`timescale 1ns/1ps
// host cpu model; lines it does not use show the inverse of their last value
module iowin_host
(
   input  wire logic        clk_in,
   output logic             wr_out = 1'b0,
   output logic             rd_out = 1'b0,
   output logic [11:0]      addr_out = 12'h000,
   output logic [31:0]      wdata_out = 32'h0,
   output logic             req_out = 1'b0,
   output logic [31:0]      haddr_out = 32'h0
);
   // one cycle per call, so back to back calls never assign a line twice
   task automatic step(input logic w, r, input logic [11:0] a, input logic [31:0] d,
                       input logic h, input logic [31:0] ha);
      wr_out = w;
      rd_out = r;
      addr_out = (w | r) ? a : ~addr_out;
      wdata_out = !w ? ~wdata_out
                : (a == iowin_pkg::BASE_SIZE_OFFSET) ? d & 32'hffff_ff9f : 32'h0;
      req_out = h;
      haddr_out = h ? ha : ~haddr_out;
      @(posedge clk_in);
   endtask
endmodule

// ==== tb/io_window_address_decode_tb_top.sv ====
`timescale 1ns/1ps
module io_window_address_decode_tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, rp = 1'b0, hp = 1'b0;
   logic [4:0]  gsc = 5'h00;
   logic [31:0] bs = 32'h0, lf = 32'hcafc, rdata, off, d, ha;
   logic        we, re, hr, on, claim, rv;
   logic [11:0] a;
   logic [31:0] qr[$];
   logic [32:0] qh[$];
   int          n_errors = 0, n_tests = 0;
   localparam logic [11:0] BS = iowin_pkg::BASE_SIZE_OFFSET;
   always #2.5 clk = ~clk;
   iowin_host host (.clk_in(clk), .wr_out(we), .rd_out(re), .addr_out(a), .wdata_out(d),
                    .req_out(hr), .haddr_out(ha));
   iowin_decode uut (.core_clk_in(clk), .reset_n_in(rst_n), .reg_wr_en_in(we),
      .reg_rd_en_in(re), .reg_addr_in(a), .reg_wdata_in(d), .reg_rdata_out(rdata),
      .reg_rd_valid_out(rv), .global_span_code_in(gsc), .host_req_in(hr),
      .host_addr_in(ha), .claim_out(claim), .claim_offset_out(off),
      .aperture_on_bit_out(on));
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction
   // expected claim and offset from the register model and the global code
   function automatic logic [32:0] want(input logic [31:0] x);
      int e;
      e = bs[4:0] > 5'h07 ? bs[4:0] + 1 : 8;
      if (gsc > 5'h07 && gsc + 1 > e) e = gsc + 1;
      return {bs[7] && ((64'(x ^ bs) >> e) == 64'h0), 32'(x & ((64'h1 << e) - 64'h1))};
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // expectations are noted before the request edge, register model after it
   task automatic op(input logic w, r, input logic [11:0] ad, input logic [31:0] dt,
                     input logic h, input logic [31:0] hx, input logic [4:0] g);
      #1;
      gsc = g;
      chk(33'(on), 33'(bs[7]));
      if (r) qr.push_back(ad == BS ? bs : 32'h0);
      if (h) qh.push_back(want(hx));
      host.step(w, r, ad, dt, h, hx);
      if (w && ad == BS) bs = dt & iowin_pkg::BASE_SIZE_WMASK;
   endtask
   // results land one cycle after their request edge
   always @(posedge clk)
   begin
      if (rp) chk({rv, rdata}, {1'b1, qr.pop_front()});
      if (hp) chk({claim, off}, qh.pop_front());
      rp <= re;
      hp <= hr;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      @(posedge clk);
      op(0, 1, BS, 0, 0, 0, 0);
      op(0, 1, iowin_pkg::CONTROL_OFFSET, 0, 0, 0, 0);
      op(1, 1, 12'h0c8, 32'hffffffff, 0, 0, 0);
      op(1, 0, BS, 32'h1000008c, 1, 32'h10000123, 0);
      op(1, 0, iowin_pkg::CONTROL_OFFSET, 32'hffffffff, 1, 32'h10000123, 0);
      for (int i = 0; i < 64; i++)
      begin
         op(1, 1, BS, (rnd() & 32'hffff_ff00) | 32'({i[5] ? i[0] : 1'b1, 2'b11, i[4:0]}),
            0, 0, 0);
         op(0, 0, BS, 0, 1, bs ^ (rnd() >> 24), i[1:0] == 0 ? 5'(rnd()) : 5'h0);
         op(0, 1, BS, 0, 1, bs ^ (rnd() >> i[4:0]), 5'h0);
         op(0, 0, BS, 0, 1, rnd(), 5'h0);
      end
      repeat (2) op(0, 0, 0, 0, 0, 0, 0);
      chk(33'(qr.size() + qh.size()), 33'h0);
      give_verdict();
   end
endmodule
